// >>> logic/jcd_pkg.sv
// package: constants and types for the debug chain and hold unit
package jcd_pkg;
  // instruction register widths
  localparam int unsigned BS_IR_W   = 5;
  localparam int unsigned CORE_IR_W = 4;
  localparam logic [4:0] BS_IR_BYPASS = 5'h1f;
  localparam logic [4:0] BS_IR_IDCODE = 5'h01;
  localparam logic [4:0] BS_IR_RESET  = 5'h01;
  // arbitrary neutral identification value
  localparam logic [31:0] BS_IDCODE = 32'h1000_0001;
  // hold control register fields
  localparam logic [31:0] HOLD_RESET = 32'h0000_0000;
  localparam logic [31:0] HOLD_MASK  = 32'h003d_ff07;
  localparam int unsigned SLP_BIT  = 0;
  localparam int unsigned DSLP_BIT = 1;
  localparam int unsigned STB_BIT  = 2;
  localparam int unsigned FWD_BIT  = 8;
  localparam int unsigned WWD_BIT  = 9;
  localparam int unsigned TMR0_BIT = 10;
  localparam int unsigned CAN0_BIT = 14;
  localparam int unsigned I2C0_BIT = 15;
  localparam int unsigned I2C1_BIT = 16;
  localparam int unsigned TMR4_BIT = 18;
  localparam int unsigned CAN1_BIT = 21;
  localparam int unsigned SYNC_W   = 4;

  typedef enum logic [3:0] {
    TS_RESET, TS_IDLE, TS_SELDR, TS_CAPDR, TS_SHDR, TS_EX1DR, TS_PAUSEDR, TS_EX2DR,
    TS_UPDDR, TS_SELIR, TS_CAPIR, TS_SHIR, TS_EX1IR, TS_PAUSEIR, TS_EX2IR, TS_UPDIR
  } jcd_tap_e;

  // probe pins after synchronisation
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
    logic trstN;
  } jcd_probe_s;

  // peripheral freeze outputs
  typedef struct packed {
    logic [6:0] timer;
    logic [1:0] i2c;
    logic [1:0] can;
    logic       fwdg;
    logic       wwdg;
  } jcd_freeze_s;
endpackage

// >>> logic/jcd_top.sv
// module: chained jtag port with boundary tap and hold-control unit
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - port uses test clock, mode select, serial in, serial out, active-low tap reset.
// - after reset the full five-signal debug configuration is selected on pins.
// - without tap reset pin, internal tap reset is held inactive at one.
// - when debug is unused, all five pins are released to general use.
// - core tap with 4-bit instruction comes first after serial in, ahead of boundary tap with 5-bit instruction.
// - in bypass the boundary tap adds exactly one bit to the data path.
// - boundary tap returns a fixed identification code when selected.
// - port registers reset by power-on only; tap reset resets tap only.
// - standby hold keeps rc clocks in standby and resets system on exit.
// - deep-sleep hold keeps bus and system clocks on rc oscillator.
// - sleep hold keeps the processor bus clock running in sleep.
// - each freeze applies only while core halted and its hold bit set.
// - frozen timers stop counting and keep their value.
// - frozen i2c units suspend smbus timeout counting.
// - frozen watchdogs have their counter clocks stopped.
// - frozen can units stop their receive register.
// - hold control resets to zero on power reset, full word access only.
// - sleep, deep-sleep, standby, free and window watchdog holds at bits 0,1,2,8,9.
// - timers 0-3 bits 10-13, can0 14, i2c 15-16, timers 4-6 18-20, can1 21.
module jcd_top (
  // clock, clock enable, power-on reset
  input  wire logic               clk,
  input  wire logic               clkEn,
  input  wire logic               rst_b,
  // probe pins
  input  wire logic               probeTestClock,
  input  wire logic               probeModeSelect,
  input  wire logic               probeSerialIn,
  output logic                    probeSerialOut,
  output logic                    probeSerialOutEn,
  input  wire logic               tapResetN,
  // pin configuration
  input  wire logic               jtagUnused,
  input  wire logic               tapResetPinUnused,
  output logic [4:0]              pinsOwnedByDebug,
  // core debug tap chain link
  output logic                    coreTdi,
  output logic                    coreTck,
  output logic                    coreTms,
  output logic                    coreTrstN,
  input  wire logic               coreTdo,
  // hold control register, full-word access
  input  wire logic               holdWrite,
  input  wire logic [31:0]        holdWdata,
  output logic [31:0]             holdRdata,
  // power modes and core state
  input  wire logic               coreHalted,
  input  wire logic               sleepMode,
  input  wire logic               deepSleepMode,
  input  wire logic               standbyMode,
  output logic                    keepCpuBusClock,
  output logic                    useRcOscClock,
  output logic                    standbyExitReset,
  output jcd_pkg::jcd_freeze_s    freeze
);

  // ---------------------------------------------------------------------------
  // reset release and synchronisers
  // ---------------------------------------------------------------------------
  logic [1:0] rstSync_reg;
  logic       rstN;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rstSync_reg <= 2'h0;
    end else begin
      rstSync_reg <= {rstSync_reg[0], 1'b1};
    end
  end
  assign rstN = rstSync_reg[1];

  logic [3:0] syncA_reg;
  logic [3:0] syncB_reg;
  jcd_pkg::jcd_probe_s pin;
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      syncA_reg <= 4'h1;
      syncB_reg <= 4'h1;
    end else if (clkEn) begin
      syncA_reg <= {probeTestClock, probeModeSelect, probeSerialIn, tapResetN};
      syncB_reg <= syncA_reg;
    end
  end
  assign pin = jcd_pkg::jcd_probe_s'({syncB_reg[3:1], syncB_reg[0] | tapResetPinUnused});

  logic tckPrev_reg;
  logic tckRise;
  logic tckFall;
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      tckPrev_reg <= 1'b0;
    end else if (clkEn) begin
      tckPrev_reg <= pin.tck;
    end
  end
  assign tckRise = pin.tck & ~tckPrev_reg;
  assign tckFall = ~pin.tck & tckPrev_reg;

  // ---------------------------------------------------------------------------
  // pin ownership
  // ---------------------------------------------------------------------------
  // debug owns pins by default
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      pinsOwnedByDebug <= 5'h1f;
    end else if (clkEn) begin
      pinsOwnedByDebug <= jtagUnused ? 5'h00 : {4'hf, ~tapResetPinUnused};
    end
  end

  // ---------------------------------------------------------------------------
  // boundary tap controller
  // ---------------------------------------------------------------------------
  jcd_pkg::jcd_tap_e tap_reg;
  jcd_pkg::jcd_tap_e tap_next;
  always_comb begin
    case (tap_reg)
      jcd_pkg::TS_RESET:   tap_next = pin.tms ? jcd_pkg::TS_RESET : jcd_pkg::TS_IDLE;
      jcd_pkg::TS_IDLE:    tap_next = pin.tms ? jcd_pkg::TS_SELDR : jcd_pkg::TS_IDLE;
      jcd_pkg::TS_SELDR:   tap_next = pin.tms ? jcd_pkg::TS_SELIR : jcd_pkg::TS_CAPDR;
      jcd_pkg::TS_CAPDR:   tap_next = pin.tms ? jcd_pkg::TS_EX1DR : jcd_pkg::TS_SHDR;
      jcd_pkg::TS_SHDR:    tap_next = pin.tms ? jcd_pkg::TS_EX1DR : jcd_pkg::TS_SHDR;
      jcd_pkg::TS_EX1DR:   tap_next = pin.tms ? jcd_pkg::TS_UPDDR : jcd_pkg::TS_PAUSEDR;
      jcd_pkg::TS_PAUSEDR: tap_next = pin.tms ? jcd_pkg::TS_EX2DR : jcd_pkg::TS_PAUSEDR;
      jcd_pkg::TS_EX2DR:   tap_next = pin.tms ? jcd_pkg::TS_UPDDR : jcd_pkg::TS_SHDR;
      jcd_pkg::TS_UPDDR:   tap_next = pin.tms ? jcd_pkg::TS_SELDR : jcd_pkg::TS_IDLE;
      jcd_pkg::TS_SELIR:   tap_next = pin.tms ? jcd_pkg::TS_RESET : jcd_pkg::TS_CAPIR;
      jcd_pkg::TS_CAPIR:   tap_next = pin.tms ? jcd_pkg::TS_EX1IR : jcd_pkg::TS_SHIR;
      jcd_pkg::TS_SHIR:    tap_next = pin.tms ? jcd_pkg::TS_EX1IR : jcd_pkg::TS_SHIR;
      jcd_pkg::TS_EX1IR:   tap_next = pin.tms ? jcd_pkg::TS_UPDIR : jcd_pkg::TS_PAUSEIR;
      jcd_pkg::TS_PAUSEIR: tap_next = pin.tms ? jcd_pkg::TS_EX2IR : jcd_pkg::TS_PAUSEIR;
      jcd_pkg::TS_EX2IR:   tap_next = pin.tms ? jcd_pkg::TS_UPDIR : jcd_pkg::TS_SHIR;
      jcd_pkg::TS_UPDIR:   tap_next = pin.tms ? jcd_pkg::TS_SELDR : jcd_pkg::TS_IDLE;
      default:             tap_next = jcd_pkg::TS_RESET;
    endcase
  end

  // tap reset acts on the controller only
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      tap_reg <= jcd_pkg::TS_RESET;
    end else if (clkEn) begin
      if (!pin.trstN) begin
        tap_reg <= jcd_pkg::TS_RESET;
      end else if (tckRise) begin
        tap_reg <= tap_next;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // boundary instruction and data registers
  // ---------------------------------------------------------------------------
  logic [4:0]  irShift_reg;
  logic [4:0]  ir_reg;
  logic [31:0] idShift_reg;
  logic        bypass_reg;
  logic        tdoNext;
  logic        shiftIr;
  logic        shiftDr;
  assign shiftIr = (tap_reg == jcd_pkg::TS_SHIR);
  assign shiftDr = (tap_reg == jcd_pkg::TS_SHDR);

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      irShift_reg <= 5'h00;
      ir_reg      <= jcd_pkg::BS_IR_RESET;
    end else if (clkEn && tckRise) begin
      if (tap_reg == jcd_pkg::TS_RESET) begin
        ir_reg <= jcd_pkg::BS_IR_RESET;
      end else if (tap_reg == jcd_pkg::TS_CAPIR) begin
        irShift_reg <= 5'h01;
      end else if (shiftIr) begin
        irShift_reg <= {coreTdo, irShift_reg[4:1]};
      end else if (tap_reg == jcd_pkg::TS_UPDIR) begin
        ir_reg <= irShift_reg;
      end
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      idShift_reg <= 32'h0000_0000;
      bypass_reg  <= 1'b0;
    end else if (clkEn && tckRise) begin
      if (tap_reg == jcd_pkg::TS_CAPDR) begin
        idShift_reg <= jcd_pkg::BS_IDCODE;
        bypass_reg  <= 1'b0;
      end else if (shiftDr) begin
        idShift_reg <= {coreTdo, idShift_reg[31:1]};
        bypass_reg  <= coreTdo;
      end
    end
  end

  always_comb begin
    if (shiftIr) begin
      tdoNext = irShift_reg[0];
    end else if (ir_reg == jcd_pkg::BS_IR_IDCODE) begin
      tdoNext = idShift_reg[0];
    end else begin
      tdoNext = bypass_reg;
    end
  end

  // serial out updates on falling test clock
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      probeSerialOut   <= 1'b0;
      probeSerialOutEn <= 1'b0;
    end else if (clkEn) begin
      if (tckFall) begin
        probeSerialOut   <= tdoNext;
        probeSerialOutEn <= (shiftIr | shiftDr) & ~jtagUnused;
      end
    end
  end

  // core tap first in chain after probe input
  // core sees its instruction behind bypass code
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      coreTdi   <= 1'b1;
      coreTck   <= 1'b0;
      coreTms   <= 1'b1;
      coreTrstN <= 1'b0;
    end else if (clkEn) begin
      coreTdi   <= pin.tdi;
      coreTck   <= pin.tck;
      coreTms   <= pin.tms;
      coreTrstN <= pin.trstN;
    end
  end

  // ---------------------------------------------------------------------------
  // hold control register
  // ---------------------------------------------------------------------------
  logic [31:0] hold_reg;
  // power reset only, full word write
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      hold_reg <= jcd_pkg::HOLD_RESET;
    end else if (clkEn && holdWrite) begin
      hold_reg <= holdWdata & jcd_pkg::HOLD_MASK;
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      holdRdata <= jcd_pkg::HOLD_RESET;
    end else if (clkEn) begin
      holdRdata <= hold_reg;
    end
  end

  // ---------------------------------------------------------------------------
  // power-mode clock keeping
  // ---------------------------------------------------------------------------
  logic standbyPrev_reg;
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      keepCpuBusClock  <= 1'b0;
      useRcOscClock    <= 1'b0;
      standbyExitReset <= 1'b0;
      standbyPrev_reg  <= 1'b0;
    end else if (clkEn) begin
      keepCpuBusClock  <= sleepMode & hold_reg[jcd_pkg::SLP_BIT];
      useRcOscClock    <= (deepSleepMode & hold_reg[jcd_pkg::DSLP_BIT])
                        | (standbyMode & hold_reg[jcd_pkg::STB_BIT]);
      standbyPrev_reg  <= standbyMode;
      standbyExitReset <= standbyPrev_reg & ~standbyMode & hold_reg[jcd_pkg::STB_BIT];
    end
  end

  // ---------------------------------------------------------------------------
  // peripheral freezes
  // ---------------------------------------------------------------------------
  // halted and hold bit
  // registered and of halt and hold
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      freeze <= '0;
    end else if (clkEn) begin
      freeze.timer <= {7{coreHalted}}
                    & {hold_reg[jcd_pkg::TMR4_BIT +: 3], hold_reg[jcd_pkg::TMR0_BIT +: 4]};
      freeze.i2c   <= {2{coreHalted}}
                    & {hold_reg[jcd_pkg::I2C1_BIT], hold_reg[jcd_pkg::I2C0_BIT]};
      freeze.can   <= {2{coreHalted}}
                    & {hold_reg[jcd_pkg::CAN1_BIT], hold_reg[jcd_pkg::CAN0_BIT]};
      freeze.fwdg  <= coreHalted & hold_reg[jcd_pkg::FWD_BIT];
      freeze.wwdg  <= coreHalted & hold_reg[jcd_pkg::WWD_BIT];
    end
  end

endmodule
`default_nettype wire

// >>> sim/jcd_checker.sv
// checker: hold unit and pin release assertions on the top ports
`timescale 1ns/1ps
`default_nettype none
module jcd_checker (
  // clock and reset
  input wire logic                 clk,
  input wire logic                 clkEn,
  input wire logic                 rst_b,
  // driven side
  input wire logic                 coreHalted,
  input wire logic                 sleepMode,
  input wire logic                 deepSleepMode,
  input wire logic                 standbyMode,
  input wire logic                 holdWrite,
  input wire logic [31:0]          holdWdata,
  input wire logic                 tapResetPinUnused,
  input wire logic                 jtagUnused,
  // observed side
  input wire logic [31:0]          holdRdata,
  input wire logic [4:0]           pinsOwnedByDebug,
  input wire logic                 coreTrstN,
  input wire logic                 keepCpuBusClock,
  input wire logic                 useRcOscClock,
  input wire logic                 standbyExitReset,
  input wire jcd_pkg::jcd_freeze_s freeze
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_hold_write:
    assert property (holdWrite && clkEn ##1 clkEn |-> ##1
      holdRdata == ($past(holdWdata, 2) & jcd_pkg::HOLD_MASK)) else $error("hold readback wrong");
  a_freeze_timer:
    assert property ($past(clkEn) |-> freeze.timer ==
      ({7{$past(coreHalted)}} & {holdRdata[20:18], holdRdata[13:10]})) else $error("timer freeze");
  a_freeze_i2c:
    assert property ($past(clkEn) |-> freeze.i2c ==
      ({2{$past(coreHalted)}} & holdRdata[16:15])) else $error("i2c freeze wrong");
  a_freeze_can:
    assert property ($past(clkEn) |-> freeze.can ==
      ({2{$past(coreHalted)}} & {holdRdata[21], holdRdata[14]})) else $error("can freeze wrong");
  a_freeze_wdg:
    assert property ($past(clkEn) |-> {freeze.fwdg, freeze.wwdg} ==
      ({2{$past(coreHalted)}} & {holdRdata[8], holdRdata[9]})) else $error("watchdog freeze");
  a_sleep_clock:
    assert property ($past(clkEn) |-> keepCpuBusClock ==
      ($past(sleepMode) && holdRdata[0])) else $error("sleep clock wrong");
  a_rc_clock:
    assert property ($past(clkEn) |-> useRcOscClock == ($past(deepSleepMode) && holdRdata[1]
      || $past(standbyMode) && holdRdata[2])) else $error("rc clock wrong");
  a_standby_exit:
    assert property (standbyExitReset |-> $past(standbyMode, 2) && !$past(standbyMode)
      && holdRdata[2]) else $error("standby exit reset wrong");
  a_trst_forced:
    assert property ($past(clkEn) && $past(tapResetPinUnused) |-> coreTrstN)
      else $error("tap reset not held inactive");
  a_pins_release:
    assert property ($rose(jtagUnused) |-> ##[1:3] pinsOwnedByDebug == 5'h00)
      else $error("pins not released");
endmodule
bind jcd_top jcd_checker chk (.clk, .clkEn, .rst_b, .coreHalted, .sleepMode, .deepSleepMode,
  .standbyMode, .holdWrite, .holdWdata, .tapResetPinUnused, .jtagUnused, .holdRdata,
  .pinsOwnedByDebug, .coreTrstN, .keepCpuBusClock, .useRcOscClock, .standbyExitReset, .freeze);
`default_nettype wire

// >>> sim/jcd_probe_model.sv
// partner: external probe driving four of the five debug pins and reading serial out
`timescale 1ns/1ps
`default_nettype none
module jcd_probe_model (
  // probe pins
  output logic     tck,
  output logic     tms,
  output logic     tdi,
  output logic     trstN,
  input wire logic tdo
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    trstN = 1'b1;
  end
  // one link clock per bit, serial out taken at rise
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #80;
    tck = 1'b1;
    q = tdo;
    #80;
    tck = 1'b0;
  endtask
  task automatic hold_reset(input logic v);
    trstN = v;
  endtask
endmodule
`default_nettype wire

// >>> sim/jcd_top_test.sv
// testbench: hold unit, pin release and identification readout
`timescale 1ns/1ps
`default_nettype none
module jcd_top_test;
  logic        clk = 1'b0;
  logic        clkEn = 1'b1;
  logic        rst_b = 1'b0;
  logic        tck, tms, tdi, trstN, tdo, tdoEn, coreTdi, coreTck, coreTms, coreTrstN;
  logic        coreTdo = 1'b0;
  logic        jtagUnused = 1'b0, trstUnused = 1'b0, holdWrite = 1'b0;
  logic        coreHalted = 1'b0, sleepMode = 1'b0, deepSleepMode = 1'b0, standbyMode = 1'b0;
  logic        keepClk, useRc, stbyRst;
  logic [4:0]  pins;
  logic [31:0] holdWdata = 32'h0;
  logic [31:0] holdRdata;
  jcd_pkg::jcd_freeze_s freeze;
  int          err_count = 0;
  int          n_checks = 0;
  int          pos [13] = '{20, 19, 18, 13, 12, 11, 10, 16, 15, 21, 14, 8, 9};

  always #4 clk = ~clk;
  // one-bit core tap stand-in
  always @(posedge coreTck) coreTdo <= coreTdi;

  jcd_top dut (
    .clk(clk), .clkEn(clkEn), .rst_b(rst_b), .probeTestClock(tck), .probeModeSelect(tms),
    .probeSerialIn(tdi), .probeSerialOut(tdo), .probeSerialOutEn(tdoEn), .tapResetN(trstN),
    .jtagUnused(jtagUnused), .tapResetPinUnused(trstUnused), .pinsOwnedByDebug(pins),
    .coreTdi(coreTdi), .coreTck(coreTck), .coreTms(coreTms), .coreTrstN(coreTrstN),
    .coreTdo(coreTdo), .holdWrite(holdWrite), .holdWdata(holdWdata), .holdRdata(holdRdata),
    .coreHalted(coreHalted), .sleepMode(sleepMode), .deepSleepMode(deepSleepMode),
    .standbyMode(standbyMode), .keepCpuBusClock(keepClk), .useRcOscClock(useRc),
    .standbyExitReset(stbyRst), .freeze(freeze));
  jcd_probe_model probe (.tck(tck), .tms(tms), .tdi(tdi), .trstN(trstN), .tdo(tdo));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [31:0] d);
    holdWdata = d;
    holdWrite = 1'b1;
    cyc(1);
    holdWrite = 1'b0;
    cyc(2);
  endtask
  task automatic t_hold();
    chk(holdRdata, jcd_pkg::HOLD_RESET);
    chk(32'(pins), 32'h1f);
    wr(32'hffff_ffff);
    chk(holdRdata, jcd_pkg::HOLD_MASK);
    clkEn = 1'b0;
    wr(32'h0);
    clkEn = 1'b1;
    cyc(2);
    chk(holdRdata, jcd_pkg::HOLD_MASK);
    $display("test hold done");
  endtask
  task automatic t_freeze();
    coreHalted = 1'b1;
    for (int k = 0; k < 13; k++) begin
      wr(32'h1 << pos[k]);
      chk(32'(freeze), 32'h1 << (12 - k));
    end
    wr(32'hffff_ffff);
    chk(32'(freeze), 32'h1fff);
    coreHalted = 1'b0;
    cyc(2);
    chk(32'(freeze), 32'h0);
    $display("test freeze done");
  endtask
  task automatic t_power();
    wr(32'h7);
    sleepMode = 1'b1;
    cyc(2);
    chk(32'(keepClk), 32'h1);
    sleepMode = 1'b0;
    deepSleepMode = 1'b1;
    cyc(2);
    chk(32'(useRc), 32'h1);
    deepSleepMode = 1'b0;
    standbyMode = 1'b1;
    cyc(2);
    chk(32'(useRc), 32'h1);
    standbyMode = 1'b0;
    cyc(1);
    chk(32'(stbyRst), 32'h1);
    cyc(1);
    chk(32'(stbyRst), 32'h0);
    wr(32'h0);
    sleepMode = 1'b1;
    cyc(2);
    chk(32'(keepClk), 32'h0);
    sleepMode = 1'b0;
    standbyMode = 1'b1;
    cyc(2);
    chk(32'(useRc), 32'h0);
    standbyMode = 1'b0;
    cyc(1);
    chk(32'(stbyRst), 32'h0);
    $display("test power done");
  endtask
  task automatic t_pins();
    wr(32'h0000_0400);
    jtagUnused = 1'b1;
    cyc(4);
    chk(32'(pins), 32'h0);
    jtagUnused = 1'b0;
    trstUnused = 1'b1;
    probe.hold_reset(1'b0);
    cyc(6);
    chk(32'(pins), 32'h1e);
    chk(32'(coreTrstN), 32'h1);
    trstUnused = 1'b0;
    cyc(6);
    chk(32'(coreTrstN), 32'h0);
    probe.hold_reset(1'b1);
    cyc(6);
    chk(holdRdata, 32'h0000_0400);
    $display("test pins done");
  endtask
  task automatic t_idcode();
    logic [8:0]  walk;
    logic [31:0] id;
    logic        q;
    walk = 9'h05f;
    id = 32'h0;
    for (int i = 0; i < 9; i++)
      probe.step(walk[i], 1'b0, q);
    for (int i = 0; i < 32; i++) begin
      probe.step(i == 31, 1'b1, q);
      id[i] = q;
      if (i == 16)
        chk(32'(tdoEn), 32'h1);
    end
    probe.step(1'b1, 1'b0, q);
    probe.step(1'b0, 1'b0, q);
    chk(id, jcd_pkg::BS_IDCODE);
    $display("test idcode done");
  endtask
  task automatic t_chain();
    logic [7:0] d;
    logic [7:0] q8;
    logic [4:0] cap;
    logic       q;
    d = 8'h2d;
    q8 = 8'h00;
    cap = 5'h00;
    // instruction scan: idle to shift-ir
    probe.step(1'b1, 1'b0, q);
    probe.step(1'b1, 1'b0, q);
    probe.step(1'b0, 1'b0, q);
    probe.step(1'b0, 1'b0, q);
    // five ones for the boundary tap, then the core stand-in bit
    for (int i = 0; i < 6; i++) begin
      probe.step(i == 5, i < 5, q);
      if (i < 5)
        cap[i] = q;
    end
    probe.step(1'b1, 1'b0, q);
    probe.step(1'b0, 1'b0, q);
    chk(32'(cap), 32'h0000_0001);
    // data scan through stand-in bit and bypass bit
    probe.step(1'b1, 1'b0, q);
    probe.step(1'b0, 1'b0, q);
    probe.step(1'b0, 1'b0, q);
    for (int i = 0; i < 8; i++) begin
      probe.step(i == 7, d[i], q);
      q8[i] = q;
    end
    probe.step(1'b1, 1'b0, q);
    probe.step(1'b0, 1'b0, q);
    chk(32'(q8), 32'({d[5:0], 2'b00}));
    chk(32'(coreTms), 32'h0);
    $display("test chain done");
  endtask
  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clk);
    #1;
    rst_b = 1'b1;
    cyc(3);
    t_hold();
    t_freeze();
    t_power();
    t_pins();
    t_idcode();
    t_chain();
    complete_run();
  end
  initial begin
    #50us;
    err_count++;
    complete_run();
  end
endmodule
`default_nettype wire
